/* File: pkg/evpa_pkg.sv */
// exception arbiter constants: vectors, priorities, register map
// assumes a 32-bit AXI4-Lite register bus on a 25 MHz system clock
package evpa_pkg;
    localparam int NUM_IRQ     = 30;
    localparam int NUM_EXC     = 46;
    localparam int EXC_W       = 6;
    localparam int PRI_W       = 3;
    localparam int IRQ_VEC_BASE = 16;
    localparam logic [29:0] IRQ_RSVD_MASK = 30'h0E00_2200;
    localparam logic [5:0] EXC_RESET  = 6'h01;
    localparam logic [5:0] EXC_NMI    = 6'h02;
    localparam logic [5:0] EXC_HARD   = 6'h03;
    localparam logic [5:0] EXC_MEM    = 6'h04;
    localparam logic [5:0] EXC_BUS    = 6'h05;
    localparam logic [5:0] EXC_USAGE  = 6'h06;
    localparam logic [5:0] EXC_SVC    = 6'h0B;
    localparam logic [5:0] EXC_DBG    = 6'h0C;
    localparam logic [5:0] EXC_PNDREQ = 6'h0E;
    localparam logic [5:0] EXC_TICK   = 6'h0F;
    localparam logic [5:0] EXC_NONE   = 6'h00;
    // effective priority: 4-bit signed-style rank, fixed ones below 0..7
    localparam logic [3:0] RANK_RESET = 4'h0;
    localparam logic [3:0] RANK_NMI   = 4'h1;
    localparam logic [3:0] RANK_HARD  = 4'h2;
    localparam logic [3:0] RANK_PROG0 = 4'h3;
    localparam logic [3:0] RANK_IDLE  = 4'hF;
    localparam logic [2:0] PRI_RESET_VAL = 3'h0;
    localparam logic [31:0] VTOR_RESET = 32'h0000_0000;
    localparam logic [31:0] VTOR_MIN   = 32'h0000_0100;
    localparam logic [31:0] VTOR_MAX   = 32'h3FFF_FF00;
    localparam logic [31:0] VTOR_MASK  = 32'hFFFF_FF00;
    // handler class codes
    localparam logic [1:0] CLS_NONE  = 2'h0;
    localparam logic [1:0] CLS_ISR   = 2'h1;
    localparam logic [1:0] CLS_FAULT = 2'h2;
    localparam logic [1:0] CLS_SYS   = 2'h3;
    // register byte offsets
    localparam logic [7:0] OFF_VTOR    = 8'h00;
    localparam logic [7:0] OFF_SYSPRI  = 8'h04;
    localparam logic [7:0] OFF_PENDSET = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0C;
    localparam logic [7:0] OFF_IRQPRI0 = 8'h10;
    localparam int         IRQPRI_REGS = 4;
    localparam int         PRI_PER_REG = 8;
    localparam int         PRI_STRIDE  = 4;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        EVPA_IDLE   = 3'b001,
        EVPA_ENTRY  = 3'b010,
        EVPA_ACTIVE = 3'b100
    } evpa_state_t;
endpackage

/* File: src/evpa_pick.sv */
// combinational arbiter: most urgent pending exception
// ties go to the lower exception number by strict compare in order
`timescale 1ns/1ns
module evpa_pick (
    input  wire logic [evpa_pkg::NUM_EXC-1:0]   pend_i,
    input  wire logic [evpa_pkg::NUM_EXC*evpa_pkg::PRI_W-1:0] pri_i,
    output logic      [evpa_pkg::EXC_W-1:0]     win_o,
    output logic      [3:0]                     rank_o
);
    // fixed exceptions rank above any 3-bit field
    function automatic logic [3:0] rank_of(input int n,
                                           input logic [2:0] p);
        if (n == int'(evpa_pkg::EXC_RESET))
            return evpa_pkg::RANK_RESET;
        if (n == int'(evpa_pkg::EXC_NMI))
            return evpa_pkg::RANK_NMI;
        if (n == int'(evpa_pkg::EXC_HARD))
            return evpa_pkg::RANK_HARD;
        return evpa_pkg::RANK_PROG0 + {1'b0, p};
    endfunction

    always_comb
    begin
        logic [3:0] r;
        win_o  = evpa_pkg::EXC_NONE;
        rank_o = evpa_pkg::RANK_IDLE;
        r      = evpa_pkg::RANK_IDLE;
        for (int n = 1; n < evpa_pkg::NUM_EXC; n++)
        begin
            r = rank_of(n, pri_i[n*evpa_pkg::PRI_W +: evpa_pkg::PRI_W]);
            // strict less: equal rank keeps lower number
            if (pend_i[n] && r < rank_o)
            begin
                win_o  = n[evpa_pkg::EXC_W-1:0];
                rank_o = r;
            end
        end
    end
endmodule

/* File: src/evpa_pri_mem.sv */
// priority storage: one 3-bit field per exception number
// assumes writes are single-field; read data are registered
`timescale 1ns/1ns
module evpa_pri_mem (
    input  wire logic                        clk_i,
    input  wire logic                        srst_i,
    input  wire logic                        ce_i,
    input  wire logic                        wr_en_i,
    input  wire logic [evpa_pkg::EXC_W-1:0]  wr_idx_i,
    input  wire logic [evpa_pkg::PRI_W-1:0]  wr_pri_i,
    input  wire logic [evpa_pkg::EXC_W-1:0]  rd_idx_i,
    output logic      [evpa_pkg::PRI_W-1:0]  rd_pri_o,
    output logic [evpa_pkg::NUM_EXC*evpa_pkg::PRI_W-1:0] all_pri_o
);
    logic [evpa_pkg::PRI_W-1:0] mem_reg [evpa_pkg::NUM_EXC];

    // every field clears to zero at reset
    genvar g;
    generate
        for (g = 0; g < evpa_pkg::NUM_EXC; g++)
        begin : g_fld
            always_ff @(posedge clk_i)
            begin
                if (srst_i)
                    mem_reg[g] <= evpa_pkg::PRI_RESET_VAL;
                else if (ce_i && wr_en_i && wr_idx_i == g)
                    mem_reg[g] <= wr_pri_i;
            end
            assign all_pri_o[g*evpa_pkg::PRI_W +: evpa_pkg::PRI_W] =
                mem_reg[g];
        end
    endgenerate

    // registered read port
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rd_pri_o <= evpa_pkg::PRI_RESET_VAL;
        else if (ce_i)
            rd_pri_o <= (int'(rd_idx_i) < evpa_pkg::NUM_EXC) ?
                mem_reg[rd_idx_i] : evpa_pkg::PRI_RESET_VAL;
    end
endmodule

/* File: src/evpa_top.sv */
// exception vector priority arbiter with AXI4-Lite registers
// assumes the core acks entry and signals handler completion
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

// Summary of operation
// - irq n is vector n+16, offset 4n+64
// - programmable priorities reset to zero
// - peripheral interrupts classed as service routines
// - hard, mem, usage, bus are faults
// - nmi, pend request, svc, tick system
// - word 0 stack pointer, others handlers
// - table base zero after reset
// - privileged relocation within allowed base range
// - smaller value is more urgent
// - values 0 to 7, fixed ones outrank
// - ties go to lowest exception number
// - preempt only for strictly more urgent
// - equal priority stays pending, no preempt
// - pend request 14, tick 15, irqs from 16
// - reset -3, nmi -2, hard -1, unmaskable
// - inactive, pending, active, active and pending
// - take pending if idle or outranking
module evpa_top (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic [29:0] peripheral_interrupt_line_i,
    input  wire logic        nmi_i,
    input  wire logic        hard_fault_i,
    input  wire logic        mem_fault_i,
    input  wire logic        bus_fault_i,
    input  wire logic        usage_fault_i,
    input  wire logic        svc_i,
    input  wire logic        systick_i,
    input  wire logic        entry_ack_i,
    input  wire logic        handler_done_i,
    output logic             entry_req_o,
    output logic [5:0]       entry_vec_o,
    output logic [31:0]      entry_addr_o,
    output logic [31:0]      sp_addr_o,
    output logic [1:0]       handler_class_o,
    output logic [5:0]       active_vec_o,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int NE = evpa_pkg::NUM_EXC;
    localparam int PW = evpa_pkg::PRI_W;

    evpa_pkg::evpa_state_t state_reg;
    logic [NE-1:0]  pend_reg;
    logic [NE-1:0]  act_reg;
    logic [NE-1:0]  src_raise;
    logic [31:0]    vector_base_offset_reg;
    logic [3:0]     run_rank_reg;
    logic [5:0]     win;
    logic [3:0]     win_rank;
    logic [NE*PW-1:0] all_pri;
    logic [2:0]     rd_pri;
    logic           take;

    // classify an exception number into its handler class
    function automatic logic [1:0] class_of(input logic [5:0] v);
        if (v >= evpa_pkg::EXC_HARD && v <= evpa_pkg::EXC_USAGE)
            return evpa_pkg::CLS_FAULT;
        if (v >= 6'(evpa_pkg::IRQ_VEC_BASE))
            return evpa_pkg::CLS_ISR;
        if (v == evpa_pkg::EXC_NONE || v == evpa_pkg::EXC_RESET)
            return evpa_pkg::CLS_NONE;
        return evpa_pkg::CLS_SYS;
    endfunction

    // ---- register bus: write side holds address and data separately
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic        aw_priv_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_go;
    logic        pend_req_set;
    logic        pri_we;
    logic [5:0]  pri_widx;
    logic [2:0]  pri_wval;
    logic        wr_ok;

    assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    // accept each write channel on its own; one write in flight
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            aw_priv_reg   <= 1'b0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= evpa_pkg::RESP_OKAY;
        end
        else if (ce_i)
        begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready;
            s_axi_wready  <= !w_hold_reg && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
                aw_priv_reg <= s_axi_awprot[0];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? evpa_pkg::RESP_OKAY
                                      : evpa_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // decode the held write into one effect
    always_comb
    begin
        wr_ok        = 1'b0;
        pend_req_set = 1'b0;
        if (wr_go)
        begin
            if (aw_addr_reg == evpa_pkg::OFF_VTOR)
                wr_ok = aw_priv_reg;
            else if (aw_addr_reg == evpa_pkg::OFF_SYSPRI)
                wr_ok = 1'b1;
            else if (aw_addr_reg == evpa_pkg::OFF_PENDSET)
            begin
                wr_ok        = 1'b1;
                pend_req_set = w_strb_reg[0] && w_data_reg[0];
            end
            else if (aw_addr_reg >= evpa_pkg::OFF_IRQPRI0 &&
                     aw_addr_reg < evpa_pkg::OFF_IRQPRI0 +
                     8'(evpa_pkg::IRQPRI_REGS * 4))
                wr_ok = 1'b1;
        end
    end

    // one priority field per write: lowest lane with a set strobe
    always_comb
    begin
        logic [5:0] base;
        base = 6'(((aw_addr_reg - evpa_pkg::OFF_IRQPRI0) >> 2) *
                  evpa_pkg::PRI_PER_REG) + 6'(evpa_pkg::IRQ_VEC_BASE);
        pri_we   = 1'b0;
        pri_widx = evpa_pkg::EXC_NONE;
        pri_wval = w_data_reg[PW-1:0];
        if (aw_addr_reg == evpa_pkg::OFF_SYSPRI)
            base = evpa_pkg::EXC_MEM;
        for (int k = evpa_pkg::PRI_PER_REG - 1; k >= 0; k--)
        begin
            if (wr_ok && w_strb_reg[k/2] &&
                (aw_addr_reg == evpa_pkg::OFF_SYSPRI ||
                 aw_addr_reg >= evpa_pkg::OFF_IRQPRI0))
            begin
                pri_we   = 1'b1;
                pri_widx = base + 6'(k);
                pri_wval = w_data_reg[k*evpa_pkg::PRI_STRIDE +: PW];
            end
        end
    end

    // vector base: zero after reset, aligned, bounded
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            vector_base_offset_reg <= evpa_pkg::VTOR_RESET;
        else if (ce_i && wr_ok && aw_addr_reg == evpa_pkg::OFF_VTOR &&
                 (w_data_reg & evpa_pkg::VTOR_MASK) >= evpa_pkg::VTOR_MIN &&
                 (w_data_reg & evpa_pkg::VTOR_MASK) <= evpa_pkg::VTOR_MAX)
            // low byte forced clear, out-of-range base ignored
            vector_base_offset_reg <= w_data_reg & evpa_pkg::VTOR_MASK;
    end

    // ---- read side: registered answer one cycle after address
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= evpa_pkg::RESP_OKAY;
        end
        else if (ce_i)
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= evpa_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    evpa_pkg::OFF_VTOR:
                        s_axi_rdata <= vector_base_offset_reg;
                    evpa_pkg::OFF_STATUS:
                        // winner's stored priority, one cycle late
                        s_axi_rdata <= {9'h000, rd_pri,
                                        2'(state_reg[2:1]),
                                        handler_class_o, run_rank_reg,
                                        win, active_vec_o};
                    evpa_pkg::OFF_PENDSET:
                        s_axi_rdata <= {31'h0000_0000,
                                        pend_reg[evpa_pkg::EXC_PNDREQ]};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        if (s_axi_araddr != evpa_pkg::OFF_SYSPRI &&
                            !(s_axi_araddr >= evpa_pkg::OFF_IRQPRI0 &&
                              s_axi_araddr < evpa_pkg::OFF_IRQPRI0 +
                              8'(evpa_pkg::IRQPRI_REGS * 4)))
                            s_axi_rresp <= evpa_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    evpa_pri_mem u_pri (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .wr_en_i   (pri_we),
        .wr_idx_i  (pri_widx),
        .wr_pri_i  (pri_wval),
        .rd_idx_i  (win),
        .rd_pri_o  (rd_pri),
        .all_pri_o (all_pri)
    );

    // ---- sources onto exception numbers
    always_comb
    begin
        src_raise = '0;
        src_raise[evpa_pkg::EXC_NMI]    = nmi_i;
        src_raise[evpa_pkg::EXC_HARD]   = hard_fault_i;
        src_raise[evpa_pkg::EXC_MEM]    = mem_fault_i;
        src_raise[evpa_pkg::EXC_BUS]    = bus_fault_i;
        src_raise[evpa_pkg::EXC_USAGE]  = usage_fault_i;
        src_raise[evpa_pkg::EXC_SVC]    = svc_i;
        src_raise[evpa_pkg::EXC_PNDREQ] = pend_req_set;
        src_raise[evpa_pkg::EXC_TICK]   = systick_i;
        // reserved lines masked off
        src_raise[NE-1:evpa_pkg::IRQ_VEC_BASE] =
            peripheral_interrupt_line_i &
            ~evpa_pkg::IRQ_RSVD_MASK;
    end

    evpa_pick u_pick (
        .pend_i (pend_reg),
        .pri_i  (all_pri),
        .win_o  (win),
        .rank_o (win_rank)
    );

    // strictly more urgent than the running one, or nothing running
    assign take = state_reg == evpa_pkg::EVPA_IDLE ? |pend_reg :
                  (state_reg == evpa_pkg::EVPA_ACTIVE &&
                   win_rank < run_rank_reg);

    // pending bits: a new raise wins over the entry clear
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            pend_reg <= '0;
        else if (ce_i)
            pend_reg <= (pend_reg &
                ~((state_reg == evpa_pkg::EVPA_ENTRY && entry_ack_i) ?
                  (NE'(1) << entry_vec_o) : '0)) |
                src_raise;
    end

    // entry handshake and running rank; one done ends all nested handlers at once
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg       <= evpa_pkg::EVPA_IDLE;
            act_reg         <= '0;
            run_rank_reg    <= evpa_pkg::RANK_IDLE;
            entry_req_o     <= 1'b0;
            entry_vec_o     <= evpa_pkg::EXC_NONE;
            entry_addr_o    <= evpa_pkg::VTOR_RESET;
            active_vec_o    <= evpa_pkg::EXC_NONE;
            handler_class_o <= evpa_pkg::CLS_NONE;
        end
        else if (ce_i)
        begin
            case (state_reg)
                evpa_pkg::EVPA_IDLE, evpa_pkg::EVPA_ACTIVE:
                begin
                    if (handler_done_i &&
                        state_reg == evpa_pkg::EVPA_ACTIVE)
                    begin
                        act_reg         <= '0;
                        run_rank_reg    <= evpa_pkg::RANK_IDLE;
                        active_vec_o    <= evpa_pkg::EXC_NONE;
                        handler_class_o <= evpa_pkg::CLS_NONE;
                        state_reg       <= evpa_pkg::EVPA_IDLE;
                    end
                    else if (take)
                    begin
                        entry_req_o  <= 1'b1;
                        entry_vec_o  <= win;
                        // handler word at base plus four times vector
                        entry_addr_o <= vector_base_offset_reg +
                                        {24'h00_0000, win, 2'b00};
                        state_reg    <= evpa_pkg::EVPA_ENTRY;
                    end
                end
                evpa_pkg::EVPA_ENTRY:
                begin
                    if (entry_ack_i)
                    begin
                        entry_req_o     <= 1'b0;
                        act_reg         <= act_reg |
                                           (NE'(1) << entry_vec_o);
                        active_vec_o    <= entry_vec_o;
                        run_rank_reg    <= win_rank;
                        handler_class_o <= class_of(entry_vec_o);
                        state_reg       <= evpa_pkg::EVPA_ACTIVE;
                    end
                end
                default:
                    state_reg <= evpa_pkg::EVPA_IDLE;
            endcase
        end
    end

    // stack pointer word is always the first table word
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            sp_addr_o <= evpa_pkg::VTOR_RESET;
        else if (ce_i)
            sp_addr_o <= vector_base_offset_reg;
    end

    AST_BASE_RESET: assert property (@(posedge clk_i)
        $fell(srst_i) |-> vector_base_offset_reg == 32'h0000_0000)
        else $error("base not zero after reset");
    AST_BASE_ALIGN: assert property (@(posedge clk_i) disable iff (srst_i)
        vector_base_offset_reg[7:0] == 8'h00)
        else $error("base not aligned");
    AST_ADDR_CALC: assert property (@(posedge clk_i) disable iff (srst_i)
        entry_req_o |-> entry_addr_o ==
            vector_base_offset_reg + {24'h00_0000, entry_vec_o, 2'b00})
        else $error("bad handler address");
    AST_NO_RSVD: assert property (@(posedge clk_i) disable iff (srst_i)
        entry_req_o |-> !(entry_vec_o == 6'd25 || entry_vec_o == 6'd29 ||
                          (entry_vec_o >= 6'd41 && entry_vec_o <= 6'd43)))
        else $error("reserved line taken");
    AST_NMI_FIRST: assert property (@(posedge clk_i) disable iff (srst_i)
        (state_reg == evpa_pkg::EVPA_IDLE && pend_reg[2] && !pend_reg[1])
        |=> entry_vec_o == 6'd2)
        else $error("nmi not chosen first");
    AST_NO_EQ_PREEMPT: assert property (@(posedge clk_i)
        disable iff (srst_i)
        (state_reg == evpa_pkg::EVPA_ACTIVE && win_rank >= run_rank_reg &&
         !handler_done_i) |=> state_reg != evpa_pkg::EVPA_ENTRY)
        else $error("preempted without higher rank");
    AST_PREEMPT: assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i && state_reg == evpa_pkg::EVPA_ACTIVE &&
         win_rank < run_rank_reg && !handler_done_i) |=> entry_req_o)
        else $error("missed preemption");
    AST_ISR_CLASS: assert property (@(posedge clk_i) disable iff (srst_i)
        (active_vec_o >= 6'd16) |-> handler_class_o == 2'h1)
        else $error("isr misclassified");
    AST_FAULT_CLASS: assert property (@(posedge clk_i) disable iff (srst_i)
        (active_vec_o >= 6'd3 && active_vec_o <= 6'd6)
        |-> handler_class_o == 2'h2)
        else $error("fault misclassified");
    AST_PEND_KEEP: assert property (@(posedge clk_i) disable iff (srst_i)
        (ce_i && src_raise[20]) |=> pend_reg[20])
        else $error("raise lost");
endmodule

/* File: test/evpa_core_model.sv */
// core stand-in: accepts each offered exception entry after a delay
// assumes entry_req_o holds until the ack has been seen
`timescale 1ns/1ns
module evpa_core_model #(parameter int ACK_DLY = 2) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic entry_req_i,
    output logic      entry_ack_o
);
    int wait_reg;
    // one ack per offer; restart keeps a lingering req from double acks
    always_ff @(posedge clk_i)
    begin
        if (srst_i || !entry_req_i || entry_ack_o)
        begin
            wait_reg    <= 0;
            entry_ack_o <= 1'b0;
        end
        else
        begin
            wait_reg    <= wait_reg + 1;
            entry_ack_o <= (wait_reg == ACK_DLY);
        end
    end
endmodule

/* File: test/testbench.sv */
// exception arbiter bench: AXI4-Lite master tasks and entry checks
// assumes core model acks offers; interrupt lines are pulsed
`timescale 1ns/1ns
module testbench;
    logic clk_i = 0, srst_i = 1, ack, done = 0, awv = 0, wv = 0, br = 0;
    logic arv = 0, rr = 0, req, awr, wr, bv, arr, rv;
    logic [29:0] irq = '0;
    logic [6:0] sys = '0;
    logic [7:0] aa = '0, ra = '0;
    logic [31:0] wd = '0, rd, eaddr, spa;
    logic [3:0] ws = '0;
    logic [2:0] ap = '0;
    logic [1:0] bresp, rresp, cls;
    logic [5:0] evec, avec;
    int fails = 0, comparisons = 0;
    evpa_top dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
        .peripheral_interrupt_line_i(irq), .nmi_i(sys[6]),
        .hard_fault_i(sys[5]), .mem_fault_i(sys[4]), .bus_fault_i(sys[3]),
        .usage_fault_i(sys[2]), .svc_i(sys[1]), .systick_i(sys[0]),
        .entry_ack_i(ack), .handler_done_i(done), .entry_req_o(req),
        .entry_vec_o(evec), .entry_addr_o(eaddr), .sp_addr_o(spa),
        .handler_class_o(cls), .active_vec_o(avec), .s_axi_awaddr(aa),
        .s_axi_awprot(ap), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arprot(3'h1),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    evpa_core_model #(.ACK_DLY(2)) core (.clk_i(clk_i), .srst_i(srst_i),
        .entry_req_i(req), .entry_ack_o(ack));
    initial forever #20 clk_i = ~clk_i;
    task automatic stop_test;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // write: both channels offered together, each dropped when taken
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [2:0] p, input logic [1:0] er);
        @(posedge clk_i);
        {aa, wd, ws, ap, awv, wv, br} <= {a, d, s, p, 3'b111};
        forever
        begin
            @(posedge clk_i);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv) break;
        end
        br <= 1'b0;
        cmp(32'(bresp), 32'(er));
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge clk_i);
        {ra, arv, rr} <= {a, 2'b11};
        forever
        begin
            @(posedge clk_i);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        rr <= 1'b0;
        cmp(rd, e);
        cmp(32'(rresp), 32'(er));
    endtask
    task automatic raise(input logic [29:0] l, input logic [6:0] s);
        @(posedge clk_i);
        {irq, sys} <= {l, s};
        @(posedge clk_i);
        {irq, sys} <= '0;
    endtask
    task automatic finish_handler;
        @(posedge clk_i);
        done <= 1'b1;
        @(posedge clk_i);
        done <= 1'b0;
    endtask
    // offer checked while it stands, then the running handler
    task automatic take(input logic [31:0] v, input logic [31:0] ad,
        input logic [31:0] c);
        while (req !== 1'b1) @(posedge clk_i);
        cmp(32'(evec), v);
        cmp(eaddr, ad);
        // whole-word entries: bit 0 of the fetched word is software's
        cmp(32'(eaddr[1:0]), 32'h0);
        while (ack !== 1'b1) @(posedge clk_i);
        @(negedge clk_i);
        cmp(32'(avec), v);
        cmp(32'(cls), c);
    endtask
    task automatic idle_check;
        repeat (4) @(posedge clk_i);
        cmp(32'(req), 32'h0);
    endtask
    initial
    begin
        #(40 * 20000);
        fails++;
        stop_test;
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_reg(8'h00, 32'h0000_0000, 2'b00);
        raise(30'h0000_0200, 7'h00);
        idle_check;
        raise(30'h0000_0001, 7'h00);
        take(16, 32'h0000_0040, 1);
        finish_handler;
        raise(30'h0000_0008, 7'h01);
        take(15, 32'h0000_003C, 3);
        finish_handler;
        take(19, 32'h0000_004C, 1);
        finish_handler;
        raise(30'h0, 7'h20);
        take(3, 32'h0000_000C, 2);
        finish_handler;
        // aligned bases only, as software must
        wr_reg(8'h00, 32'h0000_0100, 4'hF, 3'h1, 2'b00);
        wr_reg(8'h00, 32'h0000_0200, 4'hF, 3'h0, 2'b10);
        wr_reg(8'h00, 32'h4000_0000, 4'hF, 3'h1, 2'b00);
        rd_reg(8'h00, 32'h0000_0100, 2'b00);
        wr_reg(8'h40, 32'h0000_0001, 4'hF, 3'h1, 2'b10);
        rd_reg(8'h40, 32'h0000_0000, 2'b10);
        cmp(spa, 32'h0000_0100);
        wr_reg(8'h10, 32'h0000_0005, 4'h1, 3'h1, 2'b00);
        raise(30'h0000_0005, 7'h00);
        take(18, 32'h0000_0148, 1);
        raise(30'h0000_0010, 7'h00);
        idle_check;
        raise(30'h0, 7'h40);
        take(2, 32'h0000_0108, 3);
        finish_handler;
        take(20, 32'h0000_0150, 1);
        finish_handler;
        take(16, 32'h0000_0140, 1);
        finish_handler;
        wr_reg(8'h08, 32'h0000_0001, 4'h1, 3'h1, 2'b00);
        take(14, 32'h0000_0138, 3);
        finish_handler;
        stop_test;
    end
endmodule
